// ===== verilog/monitor_regs.v
// Configuration, factory test, general pin and fourth fault-status registers
// of a hardware monitor, reached over AXI4-Lite.
// Assumes all inputs are synchronous to clk_sys; limit and fault inputs come
// from the measurement engines outside.
// Summary of operation
// R01: Config bits 1:0 pick multiplexed pin role: tach, overtemp, alert, reserved.
// R02: Config bit 2 set suppresses the overtemperature output on every channel.
// R03: Limit at -64 offset-binary or -128 two's-complement disables that channel.
// R04: On overtemp, fans go full unless bit 3 picks per-fan maximum settings.
// R05: Config bits 7:4 bypass attenuators on four voltage channels.
// R06: With lock set, config and test registers ignore writes.
// R07: Test registers reset to zero and are read-only.
// R08: Input pins read back their current level in the data bit; the code inverts it when the pin's polarity bit is clear.
// R09: Output pins are driven from their data bit.
// R10: Polarity bits 4 and 5 set active level of pins two and one.
// R11: Direction bits 6 and 7 set input or output; reset makes outputs.
// R12: Status bits 3 to 5 set on remote temperature limit faults.
// R13: Status bits 6 and 7 set on current and termination voltage faults.
// R14: Reading status clears a bit only when its fault has gone.
// R15: Reserved status and pin-config bits are not writable.
// R16: Mask bits plus summary mask suppress the alert for these sources.
// R17: Reserved bits read zero; status bits stay latched until the clearing read.
//
// Decided for this implementation: register access over AXI4-Lite.
`include "monitor_regs_defs.vh"
module monitor_regs (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clk_en,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        twos_complement,
  input  wire [3:0]  chan_overtemp,
  input  wire [31:0] chan_overtemp_limit,
  input  wire [23:0] fan_max_speed,
  input  wire [4:0]  fault_in,
  input  wire        fan_tach_pin,
  input  wire        overtemp_in,
  input  wire        alert_in,
  output reg         overtemp_signal,
  output reg         mux_pin_out,
  output reg         mux_pin_oe,
  output reg  [7:0]  fan_duty_0,
  output reg  [7:0]  fan_duty_1,
  output reg  [7:0]  fan_duty_2,
  output reg         fan_override,
  output reg         fan_tach_input,
  output reg  [3:0]  divider_bypass,
  input  wire        pin_one_in,
  output wire        pin_one_out,
  output wire        pin_one_oe,
  input  wire        pin_two_in,
  output wire        pin_two_out,
  output wire        pin_two_oe,
  output reg         alert_out,
  output wire        irq
);

  function [7:0] word_index;
    input [31:0] byte_addr;
    begin
      word_index = byte_addr[9:2];
    end
  endfunction

  function mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_CFG, `IDX_TEST_ONE, `IDX_TEST_TWO, `IDX_PIN_CFG, `IDX_FAULT_STATUS,
        `IDX_FAULT_MASK, `IDX_SUMMARY_MASK, `IDX_LOCK_CTRL, `IDX_IRQ_STATUS,
        `IDX_IRQ_MASK: mapped = 1'b1;
        default:       mapped = 1'b0;
      endcase
    end
  endfunction

  reg  [7:0] cfg_r;
  reg  [7:0] test_one_r;
  reg  [7:0] test_two_r;
  reg  [7:0] pin_cfg_r;
  reg  [7:0] fault_mask_r;
  reg        summary_mask_r;
  reg        lock_r;
  reg  [1:0] irq_status_r;
  reg  [1:0] irq_mask_r;
  reg  [4:0] fault_prev_r;

  reg        aw_held_r;
  reg [31:0] aw_addr_r;
  reg        w_held_r;
  reg [31:0] w_data_r;
  reg  [3:0] w_strb_r;

  wire [4:0] fault_flags;
  wire [7:0] status_view;
  wire       pin_one_rd;
  wire       pin_two_rd;
  wire [7:0] pin_view;
  wire [7:0] wr_idx;
  wire [7:0] rd_idx;
  wire       wr_fire;
  wire       rd_fire;
  wire       wr_lane0;
  wire       status_read;
  wire [3:0] chan_enabled;
  wire       any_overtemp;
  wire [1:0] irq_events;

  // Write channels are held until both have arrived; one response at a time
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  assign wr_fire  = aw_held_r & w_held_r & ~s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid & s_axi_arready;
  assign wr_idx   = word_index(aw_addr_r);
  assign rd_idx   = word_index(s_axi_araddr);
  assign wr_lane0 = w_strb_r[0];
  assign status_read = rd_fire & (rd_idx == `IDX_FAULT_STATUS) & clk_en;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : flag_gen
      fault_latch u_latch (
        .clk_sys  (clk_sys),
        .reset    (reset),
        .clk_en   (clk_en),
        .fault    (fault_in[g]),
        .rd_clear (status_read),
        .flag_r   (fault_flags[g])
      );
    end
    for (g = 0; g < 4; g = g + 1) begin : chan_gen
      assign chan_enabled[g] = twos_complement ?
        (chan_overtemp_limit[g*8 +: 8] != `LIMIT_OFF_TWOS) :
        (chan_overtemp_limit[g*8 +: 8] != `LIMIT_OFF_OFFSET64);   // [R03]
    end
  endgenerate

  assign status_view = {fault_flags, 3'b000};                     // [R15] [R17]
  assign pin_view = {pin_cfg_r[7:4], pin_one_rd, pin_two_rd, 2'b00}; // [R17]

  pin_port u_pin_one (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .clk_en      (clk_en),
    .dir_in      (pin_cfg_r[`PIN_ONE_DIR]),
    .active_high (pin_cfg_r[`PIN_ONE_POL]),
    .data_bit    (pin_cfg_r[`PIN_ONE_DATA]),
    .pin_in      (pin_one_in),
    .pin_out     (pin_one_out),
    .pin_oe      (pin_one_oe),
    .read_bit    (pin_one_rd)
  );

  pin_port u_pin_two (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .clk_en      (clk_en),
    .dir_in      (pin_cfg_r[`PIN_TWO_DIR]),
    .active_high (pin_cfg_r[`PIN_TWO_POL]),
    .data_bit    (pin_cfg_r[`PIN_TWO_DATA]),
    .pin_in      (pin_two_in),
    .pin_out     (pin_two_out),
    .pin_oe      (pin_two_oe),
    .read_bit    (pin_two_rd)
  );

  // Bus write path
  always @(posedge clk_sys) begin
    if (reset) begin
      aw_held_r      <= 1'b0;
      aw_addr_r      <= 32'h0000_0000;
      w_held_r       <= 1'b0;
      w_data_r       <= 32'h0000_0000;
      w_strb_r       <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `RESP_OKAY;
      cfg_r          <= `CFG_RESET;
      test_one_r     <= `TEST_RESET;
      test_two_r     <= `TEST_RESET;
      pin_cfg_r      <= `PIN_RESET;                               // [R11]
      fault_mask_r   <= `STATUS_RESET;
      summary_mask_r <= 1'b0;
      lock_r         <= 1'b0;
      irq_mask_r     <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_fire) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_lane0) begin
          case (wr_idx)
            `IDX_CFG: begin
              if (!lock_r)
                cfg_r <= w_data_r[7:0];                           // [R06]
            end
            `IDX_PIN_CFG: begin
              pin_cfg_r <= w_data_r[7:0] & `PIN_WR_MASK;          // [R15]
            end
            `IDX_FAULT_MASK: begin
              fault_mask_r <= w_data_r[7:0] & `STATUS_WR_MASK;
            end
            `IDX_SUMMARY_MASK: begin
              summary_mask_r <= w_data_r[`SUMMARY_BIT];
            end
            `IDX_LOCK_CTRL: begin
              // Lock is sticky until reset
              if (w_data_r[`LOCK_BIT])
                lock_r <= 1'b1;
            end
            `IDX_IRQ_MASK: begin
              irq_mask_r <= w_data_r[`IRQ_BITS-1:0];
            end
            default: begin
              // Test registers are read-only to software [R07]
            end
          endcase
        end
      end
    end
  end

  // Bus read path
  always @(posedge clk_sys) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
        case (rd_idx)
          `IDX_CFG:          s_axi_rdata <= {24'h00_0000, cfg_r};
          `IDX_TEST_ONE:     s_axi_rdata <= {24'h00_0000, test_one_r};   // [R07]
          `IDX_TEST_TWO:     s_axi_rdata <= {24'h00_0000, test_two_r};   // [R07]
          `IDX_PIN_CFG:      s_axi_rdata <= {24'h00_0000, pin_view};     // [R08]
          `IDX_FAULT_STATUS: s_axi_rdata <= {24'h00_0000, status_view};
          `IDX_FAULT_MASK:   s_axi_rdata <= {24'h00_0000, fault_mask_r};
          `IDX_SUMMARY_MASK: s_axi_rdata <= {24'h00_0000, summary_mask_r, 7'h00};
          `IDX_LOCK_CTRL:    s_axi_rdata <= {31'h0000_0000, lock_r};
          `IDX_IRQ_STATUS:   s_axi_rdata <= {30'h0000_0000, irq_status_r};
          `IDX_IRQ_MASK:     s_axi_rdata <= {30'h0000_0000, irq_mask_r};
          default:           s_axi_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Overtemperature, fan and multiplexed pin control
  assign any_overtemp = |(chan_overtemp & chan_enabled);          // [R03]

  always @(posedge clk_sys) begin
    if (reset) begin
      overtemp_signal <= 1'b0;
      fan_override    <= 1'b0;
      fan_duty_0      <= 8'h00;
      fan_duty_1      <= 8'h00;
      fan_duty_2      <= 8'h00;
      divider_bypass  <= 4'h0;
      alert_out       <= 1'b0;
      mux_pin_out     <= 1'b0;
      mux_pin_oe      <= 1'b0;
      fan_tach_input  <= 1'b0;
    end else if (clk_en) begin
      overtemp_signal <= any_overtemp & ~cfg_r[`CFG_OT_OFF];      // [R02]
      // Fans respond to the limit even when the pin output is suppressed
      fan_override    <= any_overtemp;
      if (cfg_r[`CFG_FAN_SEL]) begin
        fan_duty_0 <= fan_max_speed[7:0];                         // [R04]
        fan_duty_1 <= fan_max_speed[15:8];
        fan_duty_2 <= fan_max_speed[23:16];
      end else begin
        fan_duty_0 <= `FAN_FULL_DUTY;                             // [R04]
        fan_duty_1 <= `FAN_FULL_DUTY;
        fan_duty_2 <= `FAN_FULL_DUTY;
      end
      divider_bypass <= cfg_r[`CFG_BYP_MSB:`CFG_BYP_LSB];         // [R05]
      alert_out <= (|(fault_flags & ~fault_mask_r[`STATUS_MSB:`STATUS_LSB]) |
                    (|fault_flags & ~summary_mask_r)) | alert_in; // [R16]
      case (cfg_r[`PINFN_MSB:`PINFN_LSB])                         // [R01]
        `PINFN_TACH: begin
          mux_pin_oe     <= 1'b0;
          mux_pin_out    <= 1'b0;
          fan_tach_input <= fan_tach_pin;
        end
        `PINFN_OVERTEMP: begin
          // Open-drain, active low
          mux_pin_oe     <= any_overtemp & ~cfg_r[`CFG_OT_OFF] | overtemp_in;
          mux_pin_out    <= 1'b0;
          fan_tach_input <= 1'b0;
        end
        `PINFN_ALERT: begin
          mux_pin_oe     <= alert_out;
          mux_pin_out    <= 1'b0;
          fan_tach_input <= 1'b0;
        end
        default: begin
          mux_pin_oe     <= 1'b0;
          mux_pin_out    <= 1'b0;
          fan_tach_input <= 1'b0;
        end
      endcase
    end
  end

  // Interrupt: new faults and the XOR of the input-pin read bits, write one to clear
  assign irq_events[`IRQ_FAULT] = |(fault_in & ~fault_prev_r);
  assign irq_events[`IRQ_PIN]   = (pin_one_rd & pin_cfg_r[`PIN_ONE_DIR]) ^
                                  (pin_two_rd & pin_cfg_r[`PIN_TWO_DIR]) ^ 1'b0;

  always @(posedge clk_sys) begin
    if (reset) begin
      irq_status_r <= 2'b00;
      fault_prev_r <= 5'h00;
    end else if (clk_en) begin
      fault_prev_r <= fault_in;
      if (wr_fire & wr_lane0 & (wr_idx == `IDX_IRQ_STATUS))
        irq_status_r <= (irq_status_r & ~w_data_r[`IRQ_BITS-1:0]) | irq_events;
      else
        irq_status_r <= irq_status_r | irq_events;
    end
  end

  assign irq = |(irq_status_r & ~irq_mask_r);

endmodule

// ===== verilog/monitor_regs_defs.vh
// Constants for the monitor configuration, pin and fault-status register slice.
// Assumes inclusion by bare name from the design files.
`ifndef MONITOR_REGS_DEFS_VH
`define MONITOR_REGS_DEFS_VH

`define IDX_CFG            8'h7D
`define IDX_TEST_ONE       8'h7E
`define IDX_TEST_TWO       8'h7F
`define IDX_PIN_CFG        8'h80
`define IDX_FAULT_STATUS   8'h81
`define IDX_FAULT_MASK     8'h83
`define IDX_SUMMARY_MASK   8'h82
`define IDX_LOCK_CTRL      8'h40
`define IDX_IRQ_STATUS     8'hF0
`define IDX_IRQ_MASK       8'hF1

`define CFG_RESET          8'h00
`define TEST_RESET         8'h00
`define PIN_RESET          8'h00
`define STATUS_RESET       8'h00

`define PINFN_LSB          0
`define PINFN_MSB          1
`define PINFN_TACH         2'b00
`define PINFN_OVERTEMP     2'b01
`define PINFN_ALERT        2'b10
`define CFG_OT_OFF         2
`define CFG_FAN_SEL        3
`define CFG_BYP_LSB        4
`define CFG_BYP_MSB        7

`define PIN_TWO_DATA       2
`define PIN_ONE_DATA       3
`define PIN_TWO_POL        4
`define PIN_ONE_POL        5
`define PIN_TWO_DIR        6
`define PIN_ONE_DIR        7
`define PIN_WR_MASK        8'hFC

`define STATUS_WR_MASK     8'hF8
`define STATUS_LSB         3
`define STATUS_MSB         7
`define LOCK_BIT           0
`define SUMMARY_BIT        7

`define LIMIT_OFF_OFFSET64 8'h00
`define LIMIT_OFF_TWOS     8'h80
`define FAN_FULL_DUTY      8'hFF

`define IRQ_BITS           2
`define IRQ_FAULT          0
`define IRQ_PIN            1

`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ===== verilog/fault_latch.v
// One sticky fault flag with clear-on-read that only clears once the fault is gone.
// Assumes fault is synchronous to clk_sys and rd_clear is a one-cycle pulse.
module fault_latch (
  input  wire clk_sys,
  input  wire reset,
  input  wire clk_en,
  input  wire fault,
  input  wire rd_clear,
  output reg  flag_r
);
  always @(posedge clk_sys) begin
    if (reset) begin
      flag_r <= 1'b0;
    end else if (clk_en) begin
      // A live fault always wins over the clearing read
      if (fault)
        flag_r <= 1'b1;                                   // [R12] [R13] [R17]
      else if (rd_clear)
        flag_r <= 1'b0;                                   // [R14]
    end
  end
endmodule

// ===== verilog/pin_port.v
// One general-purpose pin: direction, polarity and data bit.
// Assumes pin_in is synchronous to clk_sys.
module pin_port (
  input  wire clk_sys,
  input  wire reset,
  input  wire clk_en,
  input  wire dir_in,
  input  wire active_high,
  input  wire data_bit,
  input  wire pin_in,
  output reg  pin_out,
  output reg  pin_oe,
  output reg  read_bit
);
  always @(posedge clk_sys) begin
    if (reset) begin
      pin_out  <= 1'b0;
      pin_oe   <= 1'b1;
      read_bit <= 1'b0;
    end else if (clk_en) begin
      pin_oe   <= ~dir_in;                                  // [R11]
      // Asserted level depends on polarity; deasserted is the opposite
      pin_out  <= active_high ? data_bit : ~data_bit;       // [R09] [R10]
      read_bit <= dir_in ? (active_high ? pin_in : ~pin_in) : data_bit; // [R08]
    end
  end
endmodule

// ===== dv/monitor_regs_props.sv
// Checker for monitor_regs, bound to its top-level ports.
// Assumes clk_en stays high and inputs hold still while a register is read.
`include "monitor_regs_defs.vh"
module monitor_regs_props (
  input wire        clk_sys,
  input wire        reset,
  input wire        clk_en,
  input wire [31:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire [4:0]  fault_in,
  input wire [23:0] fan_max_speed,
  input wire [7:0]  fan_duty_0,
  input wire [7:0]  fan_duty_1,
  input wire        overtemp_signal,
  input wire [3:0]  divider_bypass,
  input wire        pin_one_out,
  input wire        pin_one_oe,
  input wire        pin_two_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] A_CFG = `IDX_CFG * 4;
  localparam [31:0] A_PIN = `IDX_PIN_CFG * 4;
  localparam [31:0] A_STS = `IDX_FAULT_STATUS * 4;
  reg  [31:0] rd_addr_r;
  reg  [4:0]  f1_r;
  reg  [4:0]  f2_r;
  wire        ar_go  = s_axi_arvalid && s_axi_arready && clk_en;
  wire [4:0]  held   = fault_in & f1_r & f2_r;
  wire        rd_cfg = s_axi_rvalid && rd_addr_r == A_CFG;
  // Fault history is cleared by reset so a stale fault never counts as settled
  always @(posedge clk_sys) begin
    f1_r <= reset ? 5'h0 : fault_in;
    f2_r <= reset ? 5'h0 : f1_r;
    if (ar_go)
      rd_addr_r <= s_axi_araddr;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_RST_PINS: assert property (
    $fell(reset) |-> pin_one_oe && pin_two_oe && divider_bypass == 4'h0) else $error("pins not outputs after reset");
  AST_STS_SET: assert property (
    ar_go && s_axi_araddr == A_STS && held != 5'h0 |=> (s_axi_rdata[7:3] & $past(held)) == $past(held))
    else $error("held fault not seen in status");
  AST_HI_ZERO: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits not zero");
  AST_STS_RES: assert property (
    ar_go && s_axi_araddr == A_STS |=> s_axi_rdata[2:0] == 3'h0) else $error("reserved status bits set");
  AST_BYPASS: assert property (
    rd_cfg |-> s_axi_rdata[7:4] == divider_bypass) else $error("bypass outputs differ from config");
  AST_OT_OFF: assert property (
    rd_cfg && s_axi_rdata[2] |-> !overtemp_signal) else $error("overtemp output not suppressed");
  AST_FAN: assert property (
    rd_cfg |-> (s_axi_rdata[3] ? fan_duty_1 == fan_max_speed[15:8] : fan_duty_0 == 8'hFF))
    else $error("fan duty does not follow select");
  AST_PIN_OUT: assert property (
    s_axi_rvalid && rd_addr_r == A_PIN && !s_axi_rdata[7] |-> pin_one_oe && pin_one_out == (s_axi_rdata[3] ~^ s_axi_rdata[5]))
    else $error("pin one level wrong");
  COV_FAN_MAX: cover property (rd_cfg && s_axi_rdata[3]);
  COV_STS_HELD: cover property (ar_go && s_axi_araddr == A_STS && held != 5'h0);
  COV_RST: cover property ($fell(reset));
endmodule
bind monitor_regs monitor_regs_props u_props (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .fault_in(fault_in), .fan_max_speed(fan_max_speed), .fan_duty_0(fan_duty_0),
  .fan_duty_1(fan_duty_1), .overtemp_signal(overtemp_signal), .divider_bypass(divider_bypass),
  .pin_one_out(pin_one_out), .pin_one_oe(pin_one_oe), .pin_two_oe(pin_two_oe));

// ===== dv/tb_monitor_regs.sv
// Self-checking bench for monitor_regs, driving AXI4-Lite and the side inputs.
// Assumes the design header is on the include path; clk_en is held high.
`include "monitor_regs_defs.vh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_monitor_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] A_CFG = `IDX_CFG * 4;
  localparam [31:0] A_T1  = `IDX_TEST_ONE * 4;
  localparam [31:0] A_T2  = `IDX_TEST_TWO * 4;
  localparam [31:0] A_PIN = `IDX_PIN_CFG * 4;
  localparam [31:0] A_STS = `IDX_FAULT_STATUS * 4;
  localparam [31:0] A_SUM = `IDX_SUMMARY_MASK * 4;
  localparam [31:0] A_MSK = `IDX_FAULT_MASK * 4;
  localparam [31:0] A_LCK = `IDX_LOCK_CTRL * 4;
  localparam [31:0] A_IRQ = `IDX_IRQ_STATUS * 4;
  localparam [31:0] A_IRM = `IDX_IRQ_MASK * 4;
  localparam [23:0] FMAX  = 24'h30_2010;
  reg         clk_sys, reset, aw_v, w_v, b_r, ar_v, r_r, twos, tach, p1_in, p2_in;
  reg  [31:0] aw_a, w_d, ar_a, lim, v;
  reg  [4:0]  flt;
  reg  [3:0]  ch_ot;
  reg  [1:0]  rs_last;
  wire        aw_rdy, w_rdy, b_v, ar_rdy, r_v, ot, fov, fti, p1_o, p1_oe, p2_o, p2_oe, alert, irq, mpo;
  wire [1:0]  b_rs, r_rs;
  wire [31:0] r_d;
  wire [7:0]  fd0, fd1;
  wire [3:0]  byp;
  int         error_cnt, check_count, cyc, i;
  monitor_regs uut (
    .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy),
    .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .twos_complement(twos), .chan_overtemp(ch_ot), .chan_overtemp_limit(lim), .fan_max_speed(FMAX),
    .fault_in(flt), .fan_tach_pin(tach), .overtemp_in(1'b0), .alert_in(1'b0), .overtemp_signal(ot),
    .mux_pin_out(), .mux_pin_oe(mpo), .fan_duty_0(fd0), .fan_duty_1(fd1), .fan_duty_2(), .fan_override(fov),
    .fan_tach_input(fti), .divider_bypass(byp), .pin_one_in(p1_in), .pin_one_out(p1_o), .pin_one_oe(p1_oe),
    .pin_two_in(p2_in), .pin_two_out(p2_o), .pin_two_oe(p2_oe), .alert_out(alert), .irq(irq));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task wr(input [31:0] a, input [7:0] d);
    @(posedge clk_sys);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (aw_rdy) aw_v <= 1'b0;
      if (w_rdy) w_v <= 1'b0;
    end while (!b_v);
    b_r <= 1'b0;
    rs_last = b_rs;
  endtask
  task rd(input [31:0] a);
    @(posedge clk_sys);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (ar_rdy) ar_v <= 1'b0;
    end while (!r_v);
    r_r <= 1'b0;
    v = r_d;
    rs_last = r_rs;
  endtask
  task rc(input [31:0] a, input [31:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  task t_reset;
    rc(A_CFG, 32'h0);
    `CHK({p1_oe, p2_oe}, 2'b11)
    rc(A_T1, 32'h0);
    rc(A_PIN, 32'h0);
    rc(A_STS, 32'h0);
    wr(A_T2, 8'hA5);
    rc(A_T2, 32'h0);
    rd(32'h0010);
    `CHK(rs_last, `RESP_SLVERR)
  endtask
  task t_cfg;
    for (i = 0; i < 3; i++) begin
      wr(A_CFG, i[7:0]);
      rc(A_CFG, i);
    end
    tach <= 1'b1;
    ch_ot <= 4'h1;
    wr(A_CFG, 8'hA4);
    rc(A_CFG, 32'h00A4);
    `CHK(fti, 1'b1)
    `CHK(byp, 4'hA)
    `CHK(ot, 1'b0)
    `CHK(fd0, 8'hFF)
    wr(A_CFG, 8'h58);
    rc(A_CFG, 32'h0058);
    `CHK(ot, 1'b1)
    `CHK(fov, 1'b1)
    `CHK(fd1, FMAX[15:8])
  endtask
  task ot_case(input bit t, input [7:0] l0, input [3:0] c, input bit e);
    @(posedge clk_sys);
    twos <= t;
    lim[7:0] <= l0;
    ch_ot <= c;
    repeat (4) @(posedge clk_sys);
    `CHK(ot, e)
  endtask
  task t_limit;
    ot_case(1'b0, 8'h00, 4'h1, 1'b0);
    ot_case(1'b1, 8'h80, 4'h1, 1'b0);
    ot_case(1'b1, 8'h00, 4'h1, 1'b1);
    ot_case(1'b0, 8'h80, 4'h1, 1'b1);
    ot_case(1'b1, 8'h80, 4'h3, 1'b1);
    wr(A_CFG, 8'h59);
    @(posedge clk_sys);
    `CHK({mpo, fti}, 2'b10)
    wr(A_CFG, 8'h58);
  endtask
  task t_pins;
    wr(A_PIN, 8'h2F);
    rc(A_PIN, 32'h002C);
    `CHK({p1_oe, p2_oe, p1_o, p2_o}, 4'b1110)
    wr(A_PIN, 8'h18);
    @(posedge clk_sys);
    `CHK({p1_o, p2_o}, 2'b00)
    wr(A_PIN, 8'hE0);
    p1_in <= 1'b1;
    p2_in <= 1'b1;
    rc(A_PIN, 32'h00E8);
    `CHK({p1_oe, p2_oe}, 2'b00)
    p1_in <= 1'b0;
    p2_in <= 1'b0;
    rc(A_PIN, 32'h00E4);
    wr(A_PIN, 8'h00);
  endtask
  task t_status;
    flt <= 5'b10001;
    repeat (3) @(posedge clk_sys);
    `CHK(alert, 1'b1)
    rc(A_STS, 32'h0088);
    rd(A_IRQ);
    `CHK({v[0], irq}, 2'b11)
    wr(A_IRM, 8'h03);
    `CHK(irq, 1'b0)
    wr(A_IRQ, 8'h03);
    rd(A_IRQ);
    `CHK(v[0], 1'b0)
    wr(A_STS, 8'hFF);
    flt <= 5'b00001;
    rc(A_STS, 32'h0088);
    rc(A_STS, 32'h0008);
    flt <= 5'b00000;
    rc(A_STS, 32'h0008);
    rc(A_STS, 32'h0000);
    flt <= 5'b01000;
    wr(A_MSK, 8'hF8);
    @(posedge clk_sys);
    `CHK(alert, 1'b1)
    wr(A_SUM, 8'h80);
    rc(A_STS, 32'h0040);
    `CHK(alert, 1'b0)
  endtask
  task t_lock;
    wr(A_LCK, 8'h01);
    wr(A_CFG, 8'h55);
    rc(A_CFG, 32'h0058);
    wr(A_T1, 8'hFF);
    rc(A_T1, 32'h0);
  endtask
  initial begin
    {reset, aw_v, w_v, b_r, ar_v, r_r, twos, tach, p1_in, p2_in} = 10'h200;
    {aw_a, w_d, ar_a} = 96'h0;
    lim = 32'h4040_4040;
    flt = 5'h0;
    ch_ot = 4'h0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_cfg;
    t_limit;
    t_pins;
    t_status;
    t_lock;
    print_verdict;
  end
endmodule
